// ==== core/exec_core.sv ====
`timescale 1ns/10ps
module exec_core (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    // Instruction stream
    input  wire logic [15:0]           instr_i,
    output logic                       instr_take_o,
    output logic                       discard_o,
    // File register read port
    input  wire logic [3:0]            bank_select_reg_i,
    input  wire logic [7:0]            file_rdata_i,
    output exec_pkg::file_req_type     file_req_o,
    // Table latch and pointer
    input  wire logic [7:0]            table_latch_i,
    input  wire logic                  tptr_wr_i,
    input  wire logic [21:0]           tptr_wdata_i,
    output logic                       tlat_rd_o,
    output logic [21:0]                table_pointer_o,
    // Program memory holding register write
    output exec_pkg::hold_wr_type      hold_o
);
    import exec_pkg::*;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic [3:0]  ph;
    state_type   state_q;
    state_type   state_d;
    logic [15:0] cur_q;
    logic        zero_q;
    logic [7:0]  lat_q;
    logic [1:0]  tw_mode;

    // ************************************************************
    // Phase sequencer
    // ************************************************************
    qphase_gen u_phase (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .phase_o   (ph)
    );

    assign tw_mode = cur_q[1:0];

    // ************************************************************
    // Instruction cycle sequencing
    // ************************************************************
    always_comb begin
        state_d = S_EXEC;
        case (state_q)
            S_EXEC: begin
                if (is_tw(cur_q)) begin
                    state_d = S_TW2;
                end else if (zero_q) begin
                    state_d = S_NOP;
                end
            end
            default: state_d = S_EXEC;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_q <= S_EXEC;
        end else if (ph[3]) begin
            state_q <= state_d;
        end
    end

    // Fetch stalls during the table write's second cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            instr_take_o <= 1'b1;
        end else if (ph[3]) begin
            instr_take_o <= (state_d != S_TW2);
        end else if (ph[0]) begin
            instr_take_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cur_q     <= NOP_WORD;
            discard_o <= 1'b0;
        end else if (ph[3]) begin
            discard_o <= (state_d == S_NOP);
        end else if (ph[0]) begin
            discard_o <= 1'b0;
            if (instr_take_o) begin
                cur_q <= (state_q == S_NOP) ? NOP_WORD : instr_i;
            end
        end
    end

    // ************************************************************
    // Zero-skip test
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            file_req_o <= '0;
        end else if (ph[0]) begin
            file_req_o.rd <= instr_take_o && (state_q == S_EXEC) && is_tz(instr_i);
            file_req_o.addr <= {instr_i[TZ_BANK_BIT] ? bank_select_reg_i : ACCESS_BANK,
                                instr_i[7:0]};
        end else if (ph[1]) begin
            file_req_o.rd <= 1'b0;
        end
    end

    // Read only: no write port, so flags and the register stay as they were
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            zero_q <= 1'b0;
        end else if (ph[1]) begin
            zero_q <= file_req_o.rd && (file_rdata_i == ZERO_BYTE);
        end else if (ph[3]) begin
            zero_q <= 1'b0;
        end
    end

    // ************************************************************
    // Table write
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tlat_rd_o <= 1'b0;
            lat_q     <= ZERO_BYTE;
        end else if (ph[0]) begin
            tlat_rd_o <= (state_q == S_TW2);
        end else if (ph[1]) begin
            tlat_rd_o <= 1'b0;
            if (tlat_rd_o) begin
                lat_q <= table_latch_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hold_o <= '0;
        end else if (ph[2] && state_q == S_TW2) begin
            hold_o.wr   <= 1'b1;
            hold_o.addr <= table_pointer_o;
            hold_o.data <= lat_q;
        end else begin
            hold_o.wr <= 1'b0;
        end
    end

    // Pointer moves by the instruction win over an outside load
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            table_pointer_o <= TPTR_RESET;
        end else if (ph[3] && state_q == S_EXEC && is_tw(cur_q) && tw_mode == TW_PRE_INC) begin
            table_pointer_o <= table_pointer_o + 22'h000001;
        end else if (ph[3] && state_q == S_TW2 && tw_mode == TW_POST_INC) begin
            table_pointer_o <= table_pointer_o + 22'h000001;
        end else if (ph[3] && state_q == S_TW2 && tw_mode == TW_POST_DEC) begin
            table_pointer_o <= table_pointer_o - 22'h000001;
        end else if (tptr_wr_i) begin
            table_pointer_o <= tptr_wdata_i;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_tw_two_cycles: assert property (
        (state_q == S_EXEC && ph[3] && is_tw(cur_q))
        |=> (state_q == S_TW2) [*4] ##1 state_q == S_EXEC)
        else $error("table write did not take two cycles");

    a_tw_latch_q2: assert property (
        $rose(tlat_rd_o) |-> ph[1] && state_q == S_TW2)
        else $error("latch read outside Q2 of second cycle");

    a_tw_hold_data: assert property (
        hold_o.wr |-> ph[3] && state_q == S_TW2 && hold_o.data == $past(table_latch_i, 2))
        else $error("holding write wrong phase or data");

    a_tw_preinc_addr: assert property (
        (state_q == S_EXEC && ph[3] && is_tw(cur_q) && tw_mode == TW_PRE_INC)
        |=> table_pointer_o == $past(table_pointer_o) + 22'h000001
            ##3 hold_o.wr && hold_o.addr == $past(table_pointer_o, 3))
        else $error("pre-increment write not at new address");

    a_tz_decode: assert property (
        $rose(file_req_o.rd) |-> $past(instr_i[15:9]) == TZ_OPCODE
            && file_req_o.addr[7:0] == $past(instr_i[7:0]))
        else $error("zero-skip decode mismatch");

    a_tz_skip_zero: assert property (
        (file_req_o.rd && ph[1]) |-> ##3 discard_o == (($past(file_rdata_i, 3)) == ZERO_BYTE))
        else $error("skip does not follow zero test");

    a_skip_nop_len: assert property (
        $rose(discard_o) |-> (state_q == S_NOP) [*4] ##1 state_q == S_EXEC)
        else $error("skip NOP cycle wrong length");

    a_access_bank: assert property (
        ($rose(file_req_o.rd) && !$past(instr_i[TZ_BANK_BIT]))
        |-> file_req_o.addr[11:8] == ACCESS_BANK)
        else $error("access bank not selected");

    a_banked_addr: assert property (
        ($rose(file_req_o.rd) && $past(instr_i[TZ_BANK_BIT]))
        |-> file_req_o.addr[11:8] == $past(bank_select_reg_i))
        else $error("bank select not used");

    a_tz_no_side: assert property (
        (file_req_o.rd && !tptr_wr_i) |=> $stable(table_pointer_o) && !hold_o.wr)
        else $error("zero-skip test had a side effect");

    c_tw_preinc:  cover property (hold_o.wr && tw_mode == TW_PRE_INC);
    c_tw_postdec: cover property (hold_o.wr && tw_mode == TW_POST_DEC);
    c_tz_skip:    cover property ($rose(discard_o));
    c_tz_noskip:  cover property (file_req_o.rd ##3 !discard_o && instr_take_o);
endmodule

// ==== core/exec_pkg.sv ====
package exec_pkg;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [13:0] TW_OPCODE    = 14'h0003;
    localparam logic [6:0]  TZ_OPCODE    = 7'h33;
    localparam int          TZ_BANK_BIT  = 8;
    localparam logic [1:0]  TW_MODE_NONE = 2'h0;
    localparam logic [1:0]  TW_POST_INC  = 2'h1;
    localparam logic [1:0]  TW_POST_DEC  = 2'h2;
    localparam logic [1:0]  TW_PRE_INC   = 2'h3;
    localparam logic [3:0]  ACCESS_BANK  = 4'h0;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    localparam logic [15:0] NOP_WORD     = 16'h0000;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [21:0] TPTR_RESET   = 22'h000000;
    localparam logic [3:0]  PHASE_RESET  = 4'h1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        S_EXEC = 3'b001,
        S_TW2  = 3'b010,
        S_NOP  = 3'b100
    } state_type;

    typedef struct packed {
        logic        rd;
        logic [11:0] addr;
    } file_req_type;

    typedef struct packed {
        logic        wr;
        logic [21:0] addr;
        logic [7:0]  data;
    } hold_wr_type;

    function automatic logic is_tw(input logic [15:0] w);
        return w[15:2] == TW_OPCODE;
    endfunction

    function automatic logic is_tz(input logic [15:0] w);
        return w[15:9] == TZ_OPCODE;
    endfunction

endpackage

// ==== core/qphase_gen.sv ====
`timescale 1ns/10ps
module qphase_gen (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // One-hot phase, bit 0 is Q1
    output logic [3:0]      phase_o
);
    import exec_pkg::*;

    // Each clock is one quarter of an instruction cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            phase_o <= PHASE_RESET;
        end else begin
            phase_o <= {phase_o[2:0], phase_o[3]};
        end
    end
endmodule

// ==== verification/file_space_model.sv ====
`timescale 1ns/10ps
module file_space_model (
    // Clock
    input  wire logic                  ref_clk_i,
    // Read request and returned byte
    input  wire exec_pkg::file_req_type file_req_i,
    output logic [7:0]                 file_rdata_o
);
    import exec_pkg::*;

    logic [7:0] value;
    logic [7:0] last_q = 8'h5a;

    // Zero only where the low byte repeats the bank nibble
    assign value = file_req_i.addr[7:0] ^ {2{file_req_i.addr[11:8]}};
    // Idle bus shows inverse of last byte, so a late sample never matches
    assign file_rdata_o = file_req_i.rd ? value : ~last_q;

    always @(posedge ref_clk_i) begin
        if (file_req_i.rd) begin
            last_q <= value;
        end
    end
endmodule

// ==== verification/test_exec_core.sv ====
`timescale 1ns/10ps
module test_exec_core;
    import exec_pkg::*;

    logic         ref_clk_i         = 1'b0;
    logic         rst_i             = 1'b1;
    logic [15:0]  instr_i           = 16'h0000;
    logic [3:0]   bank_select_reg_i = 4'h0;
    logic [7:0]   table_latch_i     = 8'h00;
    logic         tptr_wr_i         = 1'b0;
    logic [21:0]  tptr_wdata_i      = 22'h000000;
    logic [7:0]   file_rdata_i;
    logic         instr_take_o;
    logic         discard_o;
    logic         tlat_rd_o;
    logic [21:0]  table_pointer_o;
    file_req_type file_req_o;
    hold_wr_type  hold_o;
    logic         wr_seen;
    int           n_mismatch        = 0;
    int           n_checks          = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    exec_core i_exec_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .instr_i(instr_i),
        .instr_take_o(instr_take_o), .discard_o(discard_o),
        .bank_select_reg_i(bank_select_reg_i), .file_rdata_i(file_rdata_i),
        .file_req_o(file_req_o), .table_latch_i(table_latch_i), .tptr_wr_i(tptr_wr_i),
        .tptr_wdata_i(tptr_wdata_i), .tlat_rd_o(tlat_rd_o),
        .table_pointer_o(table_pointer_o), .hold_o(hold_o));

    file_space_model i_file_space_model (.ref_clk_i(ref_clk_i), .file_req_i(file_req_o),
        .file_rdata_o(file_rdata_i));

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(negedge ref_clk_i);
            wr_seen = wr_seen | hold_o.wr;
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic zero_skip(input logic a, input logic [3:0] bank_select_reg, input logic [7:0] f);
        logic [3:0]  bank;
        logic        skip;
        logic [21:0] ptr;
        bank = a ? bank_select_reg : 4'h0;
        skip = (f == {bank, bank});
        ptr = table_pointer_o;
        wr_seen = 1'b0;
        bank_select_reg_i = bank_select_reg;
        instr_i = {7'h33, a, f};
        tick(1);
        check("read strobe", file_req_o.rd, 1'b1);
        check("read address", file_req_o.addr, {bank, f});
        // Prefetch a pointer-moving word: a missed discard shows in the pointer
        instr_i = 16'h000f;
        bank_select_reg_i = ~bank_select_reg;
        tick(1);
        check("read strobe end", file_req_o.rd, 1'b0);
        tick(2);
        check("discard", discard_o, skip);
        check("fetch after test", instr_take_o, 1'b1);
        if (skip) begin
            tick(1);
            check("discard end", discard_o, 1'b0);
            tick(3);
            check("fetch after skip", instr_take_o, 1'b1);
        end
        check("pointer kept", table_pointer_o, ptr);
        check("no holding write", wr_seen, 1'b0);
    endtask

    task automatic table_write(input logic [1:0] mode, input logic [21:0] ptr,
                               input logic [7:0] lat);
        logic [21:0] at;
        logic [21:0] fin;
        at = (mode == 2'h3) ? ptr + 22'h000001 : ptr;
        fin = (mode == 2'h1) ? ptr + 22'h000001 : (mode == 2'h2) ? ptr - 22'h000001 : at;
        instr_i = {14'h0003, mode};
        tptr_wr_i = 1'b1;
        tptr_wdata_i = ptr;
        tick(1);
        tptr_wr_i = 1'b0;
        tptr_wdata_i = ~ptr;
        check("pointer load", table_pointer_o, ptr);
        tick(3);
        check("pointer cycle two", table_pointer_o, at);
        check("fetch stall", instr_take_o, 1'b0);
        tick(1);
        check("latch read", tlat_rd_o, 1'b1);
        table_latch_i = lat;
        tick(1);
        table_latch_i = ~lat;
        check("early write", hold_o.wr, 1'b0);
        tick(1);
        check("holding write", hold_o.wr, 1'b1);
        check("holding address", hold_o.addr, at);
        check("holding data", hold_o.data, lat);
        tick(1);
        check("write end", hold_o.wr, 1'b0);
        check("pointer final", table_pointer_o, fin);
        check("fetch resumes", instr_take_o, 1'b1);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        rst_i = 1'b0;
        check("reset fetch", instr_take_o, 1'b1);
        check("reset pointer", table_pointer_o, 22'h000000);
        zero_skip(1'b1, 4'h5, 8'h55);
        zero_skip(1'b0, 4'h5, 8'h55);
        zero_skip(1'b0, 4'h5, 8'h00);
        zero_skip(1'b1, 4'h5, 8'h00);
        zero_skip(1'b1, 4'hf, 8'hff);
        table_write(2'h3, 22'h01389a, 8'h34);
        table_write(2'h1, 22'h00a356, 8'h55);
        table_write(2'h2, 22'h000100, 8'ha5);
        table_write(2'h0, 22'h2fffff, 8'h0f);
        zero_skip(1'b0, 4'h3, 8'h00);
        stop_test();
    end

    // Whole run is near 75 clock cycles; this leaves ample margin
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
endmodule
